// *** logic/msfc_defs.vh ***
// msfc_defs.vh: register offsets, field positions and reset values of the memory scanner
// assumes: included by the scanner design files, no other dependencies
`ifndef MSFC_DEFS_VH
`define MSFC_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define MSFC_OFS_CONTROL      8'h00
`define MSFC_OFS_CUR_LOW      8'h04
`define MSFC_OFS_CUR_HIGH     8'h08
`define MSFC_OFS_CUR_UPPER    8'h0c
`define MSFC_OFS_END_LOW      8'h10
`define MSFC_OFS_END_HIGH     8'h14
`define MSFC_OFS_END_UPPER    8'h18
`define MSFC_OFS_DATA         8'h1c

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define MSFC_CTL_GO_BIT       0
`define MSFC_CTL_TRIG_BIT     1
`define MSFC_CTL_BURST_BIT    2
`define MSFC_CTL_BUSY_BIT     3
`define MSFC_CTL_DONE_BIT     4

// ----------------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------------
`define MSFC_ADDR_W           22
`define MSFC_CUR_RESET        22'h000000
`define MSFC_END_RESET        22'h3fffff
`define MSFC_UPPER_MASK       8'h3f

// axi response codes
`define MSFC_RESP_OKAY        2'b00
`define MSFC_RESP_SLVERR      2'b10

`endif

// *** logic/msfc_axil_slave.v ***
// msfc_axil_slave.v: AXI4-Lite slave front end, turns bus traffic into one-cycle
// register write and read strobes
// assumes: single clock aclk, synchronous active-low reset, one write and one read in flight
`timescale 1ns/1ps
`include "msfc_defs.vh"

module msfc_axil_slave (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axil_awaddr,
  input  wire        s_axil_awvalid,
  output reg         s_axil_awready,
  input  wire [31:0] s_axil_wdata,
  input  wire [3:0]  s_axil_wstrb,
  input  wire        s_axil_wvalid,
  output reg         s_axil_wready,
  output reg  [1:0]  s_axil_bresp,
  output reg         s_axil_bvalid,
  input  wire        s_axil_bready,
  input  wire [7:0]  s_axil_araddr,
  input  wire        s_axil_arvalid,
  output reg         s_axil_arready,
  output reg  [31:0] s_axil_rdata,
  output reg  [1:0]  s_axil_rresp,
  output reg         s_axil_rvalid,
  input  wire        s_axil_rready,
  output reg         wr_stb,
  output reg  [7:0]  wr_addr,
  output reg  [31:0] wr_data,
  output reg  [3:0]  wr_strb,
  input  wire        wr_err,
  output reg         rd_stb,
  output reg  [7:0]  rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_err
);

  reg       aw_held;
  reg       w_held;
  reg       wr_wait;
  reg       rd_wait;

  // ----------------------------------------------------------------------------
  // write path: address and data caught in either order, strobe once both held
  // ----------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b1;
      s_axil_wready  <= 1'b1;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= `MSFC_RESP_OKAY;
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      wr_wait        <= 1'b0;
      wr_stb         <= 1'b0;
      wr_addr        <= 8'h00;
      wr_data        <= 32'h00000000;
      wr_strb        <= 4'h0;
    end else begin
      wr_stb <= 1'b0;
      if (s_axil_awvalid && s_axil_awready) begin
        wr_addr        <= s_axil_awaddr;
        aw_held        <= 1'b1;
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        wr_data       <= s_axil_wdata;
        wr_strb       <= s_axil_wstrb;
        w_held        <= 1'b1;
        s_axil_wready <= 1'b0;
      end
      if (aw_held && w_held && !wr_wait && !s_axil_bvalid) begin
        wr_stb  <= 1'b1;
        wr_wait <= 1'b1;
      end
      // response two cycles after the strobe so the decoder's error is valid
      if (wr_wait && !wr_stb && !s_axil_bvalid) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wr_err ? `MSFC_RESP_SLVERR : `MSFC_RESP_OKAY;
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid  <= 1'b0;
        wr_wait        <= 1'b0;
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read path: strobe one cycle after the address, data two cycles after the strobe
  // ----------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h00000000;
      s_axil_rresp   <= `MSFC_RESP_OKAY;
      rd_wait        <= 1'b0;
      rd_stb         <= 1'b0;
      rd_addr        <= 8'h00;
    end else begin
      rd_stb <= 1'b0;
      if (s_axil_arvalid && s_axil_arready) begin
        rd_addr        <= s_axil_araddr;
        rd_stb         <= 1'b1;
        rd_wait        <= 1'b1;
        s_axil_arready <= 1'b0;
      end
      if (rd_wait && !rd_stb && !s_axil_rvalid) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata  <= rd_data;
        s_axil_rresp  <= rd_err ? `MSFC_RESP_SLVERR : `MSFC_RESP_OKAY;
      end
      if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid  <= 1'b0;
        rd_wait        <= 1'b0;
        s_axil_arready <= 1'b1;
      end
    end
  end

endmodule

// *** logic/msfc_trig_sync.v ***
// msfc_trig_sync.v: two-flop synchroniser for the external scan trigger
// assumes: trigger may come from any domain; output is a level in aclk
`timescale 1ns/1ps

module msfc_trig_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire async_in,
  output reg  sync_out
);

  reg stage_a;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage_a  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_a  <= async_in;
      sync_out <= stage_a;
    end
  end

endmodule

// *** logic/msfc_scanner.v ***
// msfc_scanner.v: memory scan fetch control, top level with AXI4-Lite registers
// assumes: arbiter grants with mem_gnt and returns word with mem_rvalid later;
// crc unit accepts a word on crc_valid when crc_ready is high
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "msfc_defs.vh"

// Functional notes
// - with trigger gating and burst both off, a fetch is requested only while the crc unit is ready.
// - with trigger gating on and burst off, a fetch also needs the synchronised trigger true.
// - with burst on, a fetch is requested regardless of the trigger setting and of crc readiness.
// - the 22-bit current address sits in three byte registers and increments after every fetch.
// - while scan_go is set, software writes to the current address bytes are ignored.
// - the current address bytes reset to zero on every reset and are readable and writable.
// - the two top bits of the upper current address byte read as zero and ignore writes.
// - a 22-bit end address resets to all ones and ignores writes while scan_go is set.
module msfc_scanner #(
  parameter DATA_W = 16
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [7:0]        s_axil_awaddr,
  input  wire              s_axil_awvalid,
  output wire              s_axil_awready,
  input  wire [31:0]       s_axil_wdata,
  input  wire [3:0]        s_axil_wstrb,
  input  wire              s_axil_wvalid,
  output wire              s_axil_wready,
  output wire [1:0]        s_axil_bresp,
  output wire              s_axil_bvalid,
  input  wire              s_axil_bready,
  input  wire [7:0]        s_axil_araddr,
  input  wire              s_axil_arvalid,
  output wire              s_axil_arready,
  output wire [31:0]       s_axil_rdata,
  output wire [1:0]        s_axil_rresp,
  output wire              s_axil_rvalid,
  input  wire              s_axil_rready,
  input  wire              scan_trigger,
  output reg               mem_req,
  output reg  [21:0]       mem_addr,
  input  wire              mem_gnt,
  input  wire              mem_rvalid,
  input  wire [DATA_W-1:0] mem_rdata,
  input  wire              crc_ready,
  output reg               crc_valid,
  output reg  [DATA_W-1:0] crc_data
);

  // fetch sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REQ  = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [1:0] ST_PUSH = 2'b11;

  // bus strobes
  wire        wr_stb;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        rd_stb;
  wire [7:0]  rd_addr;
  wire        trig_sync;
  reg         wr_err;
  reg  [31:0] rd_data;
  reg         rd_err;

  // registers and sequencer
  reg         scan_go;
  reg         trigger_gate_enable;
  reg         continuous_fetch_select;
  reg         scan_done;
  reg  [21:0] scan_current_address;
  reg  [21:0] scan_end_address;
  reg  [1:0]  state;
  reg  [DATA_W-1:0] last_word;
  wire        past_end;
  wire        want_fetch;
  wire [7:0]  cur_upper_wr;
  wire [7:0]  end_upper_wr;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // byte 0 write with lane enable; returns old value when lane is off
  function [7:0] lane_byte;
    input [7:0]  old_val;
    input [31:0] data;
    input [3:0]  strb;
    begin
      lane_byte = strb[0] ? data[7:0] : old_val;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------------
  // registered bus front end
  msfc_axil_slave u_bus (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_stb         (wr_stb),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .wr_strb        (wr_strb),
    .wr_err         (wr_err),
    .rd_stb         (rd_stb),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_err         (rd_err)
  );

  // trigger pin is asynchronous to aclk
  msfc_trig_sync u_trig (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (scan_trigger),
    .sync_out (trig_sync)
  );

  // ----------------------------------------------------------------------------
  // fetch decision
  // ----------------------------------------------------------------------------
  // end address is inclusive; once current passes it the scan is finished
  assign past_end = (scan_current_address > scan_end_address);

  // mode table: burst ignores the trigger setting and the crc readiness
  // trigger is read only after its synchroniser
  assign want_fetch = continuous_fetch_select ? 1'b1 :
                      trigger_gate_enable ? (crc_ready && trig_sync) :
                      crc_ready;

  // upper bytes keep six bits, top lanes dropped
  assign cur_upper_wr = lane_byte({2'b00, scan_current_address[21:16]}, wr_data, wr_strb);
  assign end_upper_wr = lane_byte({2'b00, scan_end_address[21:16]}, wr_data, wr_strb);

  // ----------------------------------------------------------------------------
  // register writes, scan sequencer
  // ----------------------------------------------------------------------------
  // sequencer and registers share one process so the address has a single driver
  always @(posedge aclk) begin
    if (!aresetn) begin
      scan_go                 <= 1'b0;
      trigger_gate_enable     <= 1'b0;
      continuous_fetch_select <= 1'b0;
      scan_done               <= 1'b0;
      scan_current_address    <= `MSFC_CUR_RESET;
      scan_end_address        <= `MSFC_END_RESET;
      state                   <= ST_IDLE;
      mem_req                 <= 1'b0;
      mem_addr                <= 22'h000000;
      crc_valid               <= 1'b0;
      crc_data                <= {DATA_W{1'b0}};
      last_word               <= {DATA_W{1'b0}};
      wr_err                  <= 1'b0;
    end else begin
      wr_err <= 1'b0;
      // software write decode
      if (wr_stb) begin
        if (wr_addr == `MSFC_OFS_CONTROL) begin
          if (wr_strb[0]) begin
            scan_go                 <= wr_data[`MSFC_CTL_GO_BIT];
            trigger_gate_enable     <= wr_data[`MSFC_CTL_TRIG_BIT];
            continuous_fetch_select <= wr_data[`MSFC_CTL_BURST_BIT];
            // a new go clears done
            if (wr_data[`MSFC_CTL_GO_BIT])
              scan_done <= 1'b0;
          end
        end else if (wr_addr == `MSFC_OFS_CUR_LOW) begin
          if (!scan_go)
            scan_current_address[7:0] <= lane_byte(scan_current_address[7:0],
                                                   wr_data, wr_strb);
        end else if (wr_addr == `MSFC_OFS_CUR_HIGH) begin
          if (!scan_go)
            scan_current_address[15:8] <= lane_byte(scan_current_address[15:8],
                                                    wr_data, wr_strb);
        end else if (wr_addr == `MSFC_OFS_CUR_UPPER) begin
          if (!scan_go)
            scan_current_address[21:16] <= cur_upper_wr[5:0];
        end else if (wr_addr == `MSFC_OFS_END_LOW) begin
          if (!scan_go)
            scan_end_address[7:0] <= lane_byte(scan_end_address[7:0], wr_data, wr_strb);
        end else if (wr_addr == `MSFC_OFS_END_HIGH) begin
          if (!scan_go)
            scan_end_address[15:8] <= lane_byte(scan_end_address[15:8], wr_data, wr_strb);
        end else if (wr_addr == `MSFC_OFS_END_UPPER) begin
          if (!scan_go)
            scan_end_address[21:16] <= end_upper_wr[5:0];
        end else if (wr_addr == `MSFC_OFS_DATA) begin
          wr_err <= 1'b0;  // read-only word, writes dropped silently
        end else begin
          wr_err <= 1'b1;
        end
      end

      // limitation: an end of 3fffff never ends a scan
      // fetch sequencer; a clear of scan_go stops new requests but a granted fetch completes
      case (state)
        // idle: end check, then mode gate
        ST_IDLE: begin
          if (scan_go && past_end) begin
            scan_go   <= 1'b0;  // scan complete
            scan_done <= 1'b1;
          end else if (scan_go && want_fetch) begin
            mem_req  <= 1'b1;
            mem_addr <= scan_current_address;
            state    <= ST_REQ;
          end
        end

        // request: grant bumps the address
        ST_REQ: begin
          if (mem_gnt) begin
            mem_req              <= 1'b0;
            scan_current_address <= scan_current_address + 22'h000001;
            state                <= ST_WAIT;
          end else if (!scan_go || (!want_fetch && !continuous_fetch_select)) begin
            mem_req <= 1'b0;    // condition dropped before the arbiter answered
            state   <= ST_IDLE;
          end
        end

        // wait: word comes back later
        ST_WAIT: begin
          if (mem_rvalid) begin
            crc_valid <= 1'b1;
            crc_data  <= mem_rdata;
            last_word <= mem_rdata;
            state     <= ST_PUSH;
          end
        end

        // push: hold until the crc takes it
        default: begin
          if (crc_ready) begin
            crc_valid <= 1'b0;
            state     <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------------
  // a read strobe captures the view; the bus module presents it a cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= 32'h00000000;
      rd_err  <= 1'b0;
    end else if (rd_stb) begin
      rd_err <= 1'b0;
      if (rd_addr == `MSFC_OFS_CONTROL) begin
        rd_data <= {27'h0000000, scan_done, (state != ST_IDLE),
                    continuous_fetch_select, trigger_gate_enable, scan_go};
      end else if (rd_addr == `MSFC_OFS_CUR_LOW) begin
        rd_data <= {24'h000000, scan_current_address[7:0]};
      end else if (rd_addr == `MSFC_OFS_CUR_HIGH) begin
        rd_data <= {24'h000000, scan_current_address[15:8]};
      end else if (rd_addr == `MSFC_OFS_CUR_UPPER) begin
        rd_data <= {26'h0000000, scan_current_address[21:16]};
      end else if (rd_addr == `MSFC_OFS_END_LOW) begin
        rd_data <= {24'h000000, scan_end_address[7:0]};
      end else if (rd_addr == `MSFC_OFS_END_HIGH) begin
        rd_data <= {24'h000000, scan_end_address[15:8]};
      end else if (rd_addr == `MSFC_OFS_END_UPPER) begin
        rd_data <= {26'h0000000, scan_end_address[21:16]};
      end else if (rd_addr == `MSFC_OFS_DATA) begin
        rd_data <= {{(32-DATA_W){1'b0}}, last_word};
      end else begin
        // unmapped: zero data, error response
        rd_data <= 32'h00000000;
        rd_err  <= 1'b1;
      end
    end
  end

endmodule

// *** sim/msfc_checker.sv ***
// msfc_checker.sv: port-level assertions for the memory scanner
// assumes: bound to msfc_scanner, one clock aclk, synchronous active-low reset
`timescale 1ns/1ps

module msfc_checker #(
  parameter DATA_W = 16
) (
  input wire              aclk,
  input wire              aresetn,
  input wire              s_axil_awvalid,
  input wire              s_axil_awready,
  input wire              s_axil_wvalid,
  input wire              s_axil_wready,
  input wire              s_axil_bvalid,
  input wire              s_axil_bready,
  input wire              s_axil_arvalid,
  input wire              s_axil_arready,
  input wire              s_axil_rvalid,
  input wire              s_axil_rready,
  input wire [31:0]       s_axil_rdata,
  input wire              mem_req,
  input wire [21:0]       mem_addr,
  input wire              mem_gnt,
  input wire              mem_rvalid,
  input wire [DATA_W-1:0] mem_rdata,
  input wire              crc_ready,
  input wire              crc_valid,
  input wire [DATA_W-1:0] crc_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a waiting request keeps its address, else the arbiter fetches garbage
  property p_addr_hold; mem_req && !mem_gnt ##1 mem_req |-> $stable(mem_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
  property p_gnt_drop; mem_req && mem_gnt |=> !mem_req; endproperty
  a_gnt_drop: assert property (p_gnt_drop) else $error("request after grant");
  property p_crc_fwd; mem_rvalid |=> crc_valid && crc_data == $past(mem_rdata); endproperty
  a_crc_fwd: assert property (p_crc_fwd) else $error("word not forwarded");
  property p_crc_hold; crc_valid && !crc_ready |=> crc_valid && $stable(crc_data); endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc word dropped");
  // bus answers stand until taken
  property p_bhold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_blat;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##4 s_axil_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_rlat; s_axil_arvalid && s_axil_arready |-> ##3 s_axil_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");

  c_fetch: cover property (mem_req && mem_gnt);
  c_req_stalled: cover property (mem_req && !crc_ready);
  c_crc_stall: cover property (crc_valid && !crc_ready ##1 crc_valid);
endmodule

bind msfc_scanner msfc_checker #(.DATA_W(DATA_W)) u_msfc_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid),
  .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
  .s_axil_wready(s_axil_wready), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .s_axil_rdata(s_axil_rdata),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
  .mem_rdata(mem_rdata), .crc_ready(crc_ready), .crc_valid(crc_valid), .crc_data(crc_data));

// *** sim/msfc_mem_model.sv ***
// msfc_mem_model.sv: arbiter, memory and crc unit facing the scanner
// assumes: bench drives crc_stall; each word is a fixed function of its address
`timescale 1ns/1ps

module msfc_mem_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        mem_req,
  input  wire [21:0] mem_addr,
  output wire        mem_gnt,
  output reg         mem_rvalid = 1'b0,
  output reg  [15:0] mem_rdata = 16'h0,
  output reg         crc_ready = 1'b0,
  input  wire        crc_stall
);
  reg [21:0] pa;
  reg [1:0]  wt;
  reg        pend = 1'b0;
  reg        gok = 1'b0;
  // a random higher priority source blocks the grant some cycles
  assign mem_gnt = mem_req && gok && !pend;
  // one fetch in flight; idle data toggles so stale values never match
  always @(posedge aclk) begin
    gok <= ($urandom % 3) != 0;
    crc_ready <= !crc_stall && (($urandom % 4) != 0);
    mem_rvalid <= 1'b0;
    if (!aresetn) begin
      pend <= 1'b0;
    end else if (mem_gnt) begin
      pend <= 1'b1;
      pa <= mem_addr;
      wt <= 2'($urandom % 3);
    end else if (pend && wt != 2'h0) begin
      wt <= wt - 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (pend) begin
      pend <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata <= pa[15:0] ^ 16'h5a3c;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// *** sim/test_memory_scan_fetch_control.sv ***
// test_memory_scan_fetch_control.sv: self-checking bench for the memory scanner
// assumes: AXI4-Lite register map of msfc_defs.vh, fetch side modelled by msfc_mem_model
`timescale 1ns/1ps
`include "msfc_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module test_memory_scan_fetch_control;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         trig = 1'b0;
  reg         stall = 1'b0;
  reg         seen = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        mem_req, mem_gnt, mem_rvalid, crc_ready, crc_valid;
  wire [21:0] mem_addr;
  wire [15:0] mem_rdata, crc_data;
  reg  [31:0] rd;
  reg  [1:0]  rr, br;
  reg  [7:0]  v8;
  reg  [21:0] s, e, ea, v22;
  int         miscompares = 0, total_checks = 0, cyc = 0, nw, n, k;

  msfc_scanner u_msfc_scanner (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'h1),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .scan_trigger(trig), .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .crc_ready(crc_ready),
    .crc_valid(crc_valid), .crc_data(crc_data));
  msfc_mem_model u_msfc_mem_model (
    .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .crc_ready(crc_ready), .crc_stall(stall));

  always #20 aclk = ~aclk;

  function automatic [15:0] exp_word(input [21:0] a);
    exp_word = a[15:0] ^ 16'h5a3c;
  endfunction

  // words reaching the crc unit must follow the address sequence
  always @(posedge aclk) begin
    cyc++;
    if (mem_req === 1'b1) seen = 1'b1;
    if (crc_valid === 1'b1 && crc_ready === 1'b1) begin
      `CHK(crc_data, exp_word(ea))
      ea++;
      nw++;
    end
    if (cyc == 30000) begin
      miscompares++;
      complete_run;
    end
  end

  task complete_run;
    begin
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // address and data offered together, each dropped once taken
  task axw(input [7:0] a, input [7:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (awvalid || wvalid) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      while (!bvalid) @(posedge aclk);
      br = bresp;
      bready <= 1'b0;
    end
  endtask

  task axr(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
    end
  endtask

  task rd22(input [7:0] b);
    begin
      v22 = 22'h0;
      for (int i = 0; i < 3; i++) begin
        axr(b + 8'(4 * i));
        v22 = v22 | (22'(rd[7:0]) << (8 * i));
      end
    end
  endtask

  task chk_rst;
    begin
      rd22(`MSFC_OFS_CUR_LOW);
      `CHK(v22, `MSFC_CUR_RESET)
      rd22(`MSFC_OFS_END_LOW);
      `CHK(v22, `MSFC_END_RESET)
      axr(8'h40);
      `CHK(rr, `MSFC_RESP_SLVERR)
    end
  endtask

  initial begin
    void'($urandom(32'hda1a2373));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst;
    $display("test reset values done");
    // write and read back each current address byte; the upper byte keeps six bits
    for (k = 0; k < 12; k++) begin
      v8 = k < 3 ? 8'hff : 8'($urandom);
      axw(8'(4 + 4 * (k % 3)), v8);
      axr(8'(4 + 4 * (k % 3)));
      `CHK(rd, {24'h0, k % 3 == 2 ? v8 & `MSFC_UPPER_MASK : v8})
    end
    $display("test address bytes done");
    // modes 0 plain, 1 trigger gated, 2 and 3 continuous fetch
    for (int m = 0; m < 4; m++) begin
      s = m == 0 ? 22'h00fffe : 22'($urandom) & 22'h3ffff0;
      n = 2 + $urandom % 6;
      e = s + 22'(n);
      for (int i = 0; i < 3; i++) begin
        axw(8'(4 + 4 * i), 8'(s >> (8 * i)));
        axw(8'(16 + 4 * i), 8'(e >> (8 * i)));
      end
      ea = s;
      nw = 0;
      stall <= 1'b1;
      trig <= 1'b0;
      seen = 1'b0;
      axw(`MSFC_OFS_CONTROL, 8'(m * 2 + 1));
      axw(`MSFC_OFS_CUR_LOW, ~s[7:0]);
      `CHK(br, `MSFC_RESP_OKAY)
      axw(`MSFC_OFS_END_LOW, ~e[7:0]);
      repeat (10) @(posedge aclk);
      `CHK(seen, m[1])
      stall <= 1'b0;
      repeat (12) @(posedge aclk);
      if (m == 1) `CHK(seen, 1'b0)
      trig <= 1'b1;
      rd = 32'h0;
      for (k = 0; k < 200 && rd[4] !== 1'b1; k++) axr(`MSFC_OFS_CONTROL);
      `CHK({rd[4], rd[0]}, 2'b10)
      `CHK(nw, n + 1)
      rd22(`MSFC_OFS_CUR_LOW);
      `CHK(v22, e + 22'h1)
      rd22(`MSFC_OFS_END_LOW);
      `CHK(v22, e)
    end
    $display("test scan modes done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst;
    $display("test second reset done");
    complete_run;
  end
endmodule
